// [hdl/ivm_pkg.sv]
// ************************************************************
// Vector map constants
// ************************************************************
package ivm_pkg;

  localparam int          ADDR_W         = 12;
  localparam int          NUM_SRC        = 25;
  localparam int          SRC_W          = 5;
  localparam logic [ADDR_W-1:0] RESET_ADDR_APP = 12'h000;
  localparam logic [ADDR_W-1:0] ZERO_BASE      = 12'h000;
  localparam logic [1:0]  SETTLE_LAST    = 2'h2;
  localparam logic [1:0]  SETTLE_INIT    = 2'h0;
  localparam logic [1:0]  SETTLE_STEP    = 2'h1;
  localparam logic        FUSE_UNPROG    = 1'b1;
  localparam logic [NUM_SRC-1:0] NO_PENDING = 25'h0000000;
  localparam logic [NUM_SRC-1:0] ONE_SRC    = 25'h0000001;

  typedef enum logic [SRC_W-1:0] {
    SRC_EXT0, SRC_EXT1, SRC_PIN0, SRC_PIN1, SRC_PIN2, SRC_WDOG,
    SRC_T2_CMPA, SRC_T2_CMPB, SRC_T2_WRAP,
    SRC_T1_CAP, SRC_T1_CMPA, SRC_T1_CMPB, SRC_T1_WRAP,
    SRC_T0_CMPA, SRC_T0_CMPB, SRC_T0_WRAP,
    SRC_SPI_DONE, SRC_SER_RX, SRC_SER_EMPTY, SRC_SER_TX,
    SRC_ADC_DONE, SRC_EE_RDY, SRC_ACOMP, SRC_TWO_WIRE, SRC_PROG_RDY
  } ivm_src_t;

  typedef enum {ST_SETTLE, ST_RESET, ST_IDLE, ST_IRQ} ivm_state_t;

  localparam logic [ADDR_W-1:0] OFF_EXT0      = 12'h001;
  localparam logic [ADDR_W-1:0] OFF_EXT1      = 12'h002;
  localparam logic [ADDR_W-1:0] OFF_PIN0      = 12'h003;
  localparam logic [ADDR_W-1:0] OFF_PIN1      = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_PIN2      = 12'h005;
  localparam logic [ADDR_W-1:0] OFF_WDOG      = 12'h006;
  localparam logic [ADDR_W-1:0] OFF_T2_CMPA   = 12'h007;
  localparam logic [ADDR_W-1:0] OFF_T2_CMPB   = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_T2_WRAP   = 12'h009;
  localparam logic [ADDR_W-1:0] OFF_T1_CAP    = 12'h00A;
  localparam logic [ADDR_W-1:0] OFF_T1_CMPA   = 12'h00B;
  localparam logic [ADDR_W-1:0] OFF_T1_CMPB   = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_T1_WRAP   = 12'h00D;
  localparam logic [ADDR_W-1:0] OFF_T0_CMPA   = 12'h00E;
  localparam logic [ADDR_W-1:0] OFF_T0_CMPB   = 12'h00F;
  localparam logic [ADDR_W-1:0] OFF_T0_WRAP   = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_SPI_DONE  = 12'h011;
  localparam logic [ADDR_W-1:0] OFF_SER_RX    = 12'h012;
  localparam logic [ADDR_W-1:0] OFF_SER_EMPTY = 12'h013;
  localparam logic [ADDR_W-1:0] OFF_SER_TX    = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_ADC_DONE  = 12'h015;
  localparam logic [ADDR_W-1:0] OFF_EE_RDY    = 12'h016;
  localparam logic [ADDR_W-1:0] OFF_ACOMP     = 12'h017;
  localparam logic [ADDR_W-1:0] OFF_TWO_WIRE  = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_PROG_RDY  = 12'h019;

  // Indexed by ivm_src_t, element 0 first
  localparam logic [ADDR_W-1:0] VEC_OFFSET [NUM_SRC] = '{
    OFF_EXT0, OFF_EXT1, OFF_PIN0, OFF_PIN1, OFF_PIN2, OFF_WDOG,
    OFF_T2_CMPA, OFF_T2_CMPB, OFF_T2_WRAP,
    OFF_T1_CAP, OFF_T1_CMPA, OFF_T1_CMPB, OFF_T1_WRAP,
    OFF_T0_CMPA, OFF_T0_CMPB, OFF_T0_WRAP,
    OFF_SPI_DONE, OFF_SER_RX, OFF_SER_EMPTY, OFF_SER_TX,
    OFF_ADC_DONE, OFF_EE_RDY, OFF_ACOMP, OFF_TWO_WIRE, OFF_PROG_RDY
  };

endpackage : ivm_pkg

// [hdl/ivm_vector_map.sv]
// Operation
// - Unprogrammed boot fuse gives reset vector at word zero after any reset.
// - External requests 0 and 1 map to offsets one and two.
// - Pin change requests 0, 1, 2 map to offsets three to five.
// - Watchdog time-out maps to offset six.
// - Timer 2 compare A, compare B, overflow map to seven, eight, nine.
// - Timer 1 capture, compare A, compare B, overflow map to 0x00A-0x00D.
// - Timer 0 compare A, compare B, overflow map to 0x00E-0x010.
// - Serial peripheral transfer complete maps to 0x011.
// - Serial port receive, buffer empty, transmit done map to 0x012-0x014.
// - Converter done maps to 0x015, EEPROM ready to 0x016.
// - Comparator, two-wire, program store ready map to 0x017-0x019.
// - Programmed boot fuse takes reset vector from boot loader reset address.
// - Table select set adds boot section start to each table offset.
// - Fuse alone picks reset address; select bit alone picks table base.
// - Besides the reset vector, a vector is presented only when an interrupt is taken.
`timescale 1ns/100ps
`default_nettype none

module ivm_vector_map
  import ivm_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              boot_reset_select_fuse,
  input  wire logic              vector_table_select_bit,
  input  wire logic [ADDR_W-1:0] boot_reset_addr,
  input  wire logic              global_int_enable,
  input  wire logic [NUM_SRC-1:0] irq_pending,
  input  wire logic              vector_ack,
  output var  logic [ADDR_W-1:0] vector_addr_reg,
  output var  logic [SRC_W-1:0]  vector_src_reg,
  output var  logic              vector_is_reset_reg,
  output logic                   vector_valid,
  output logic [NUM_SRC-1:0]     irq_taken
);

  // ************************************************************
  // Reset and fuse synchronisers
  // ************************************************************
  logic       rst_meta_reg;
  logic       rst_sync_n;
  logic       fuse_meta_reg;
  logic       fuse_sync_reg;
  ivm_state_t state_reg;
  ivm_src_t   src_next;
  logic [1:0] settle_reg;
  logic       vsel_taken_reg;
  logic [ADDR_W-1:0] base_taken_reg;
  logic [NUM_SRC-1:0] pend_snap_reg;
  logic       take;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_n   <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_n   <= rst_meta_reg;
    end
  end

  // Fuse is a static strap; sampled only after release settles
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      fuse_meta_reg <= FUSE_UNPROG;
      fuse_sync_reg <= FUSE_UNPROG;
    end
    else
    begin
      fuse_meta_reg <= boot_reset_select_fuse;
      fuse_sync_reg <= fuse_meta_reg;
    end
  end

  // ************************************************************
  // Priority pick
  // ************************************************************
  always_comb
  begin
    src_next = SRC_EXT0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (irq_pending[i])
      begin
        src_next = ivm_src_t'(SRC_W'(i));
      end
    end
  end

  assign take         = (state_reg == ST_IDLE) && global_int_enable && (irq_pending != NO_PENDING);
  assign vector_valid = (state_reg == ST_RESET) || (state_reg == ST_IRQ);
  assign irq_taken    = (vector_ack && state_reg == ST_IRQ) ? (ONE_SRC << vector_src_reg) : NO_PENDING;

  // ************************************************************
  // Sequencer
  // ************************************************************
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state_reg  <= ST_SETTLE;
      settle_reg <= SETTLE_INIT;
    end
    else
    begin
      case (state_reg)
        ST_SETTLE:
        begin
          settle_reg <= settle_reg + SETTLE_STEP;
          if (settle_reg == SETTLE_LAST)
          begin
            state_reg <= ST_RESET;
          end
        end
        ST_RESET:
        begin
          if (vector_ack)
          begin
            state_reg <= ST_IDLE;
          end
        end
        ST_IDLE:
        begin
          if (take)
          begin
            state_reg <= ST_IRQ;
          end
        end
        ST_IRQ:
        begin
          if (vector_ack)
          begin
            state_reg <= ST_IDLE;
          end
        end
        default:
        begin
          state_reg <= ST_SETTLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Vector address
  // ************************************************************
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      vector_addr_reg     <= RESET_ADDR_APP;
      vector_src_reg      <= SRC_W'(SRC_EXT0);
      vector_is_reset_reg <= 1'b1;
      vsel_taken_reg      <= 1'b0;
      base_taken_reg      <= ZERO_BASE;
      pend_snap_reg       <= NO_PENDING;
    end
    else if (state_reg == ST_SETTLE && settle_reg == SETTLE_LAST)
    begin
      // Reset address ignores the table select bit
      vector_is_reset_reg <= 1'b1;
      if (fuse_sync_reg == FUSE_UNPROG)
      begin
        vector_addr_reg <= RESET_ADDR_APP;
      end
      else
      begin
        vector_addr_reg <= boot_reset_addr;
      end
    end
    else if (take)
    begin
      vector_is_reset_reg <= 1'b0;
      vector_src_reg      <= src_next;
      vsel_taken_reg      <= vector_table_select_bit;
      base_taken_reg      <= boot_reset_addr;
      pend_snap_reg       <= irq_pending;
      // Table base depends on the select bit only, never on the fuse
      if (vector_table_select_bit)
      begin
        vector_addr_reg <= boot_reset_addr + VEC_OFFSET[src_next];
      end
      else
      begin
        vector_addr_reg <= ZERO_BASE + VEC_OFFSET[src_next];
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_reset_app_addr: assert property (@(posedge clk) disable iff (!rst_sync_n)
    $rose(state_reg == ST_RESET) && $past(fuse_sync_reg) |-> vector_addr_reg == RESET_ADDR_APP)
    else $error("reset vector not zero with fuse unprogrammed");
  a_reset_boot_addr: assert property (@(posedge clk) disable iff (!rst_sync_n)
    $rose(state_reg == ST_RESET) && !$past(fuse_sync_reg) |-> vector_addr_reg == $past(boot_reset_addr))
    else $error("reset vector not boot address with fuse programmed");
  a_reset_reached: assert property (@(posedge clk) disable iff (!rst_sync_n)
    $rose(rst_sync_n) |-> ##[1:4] (state_reg == ST_RESET))
    else $error("reset vector not presented after release");
  a_ext_offsets: assert property (@(posedge clk) disable iff (!rst_sync_n)
    state_reg == ST_IRQ && !vsel_taken_reg && vector_src_reg == SRC_EXT1 |-> vector_addr_reg == OFF_EXT1)
    else $error("external request 1 offset wrong");
  a_pin_offsets: assert property (@(posedge clk) disable iff (!rst_sync_n)
    state_reg == ST_IRQ && !vsel_taken_reg && vector_src_reg == SRC_PIN2 |-> vector_addr_reg == OFF_PIN2)
    else $error("pin change 2 offset wrong");
  a_wdog_offset: assert property (@(posedge clk) disable iff (!rst_sync_n)
    state_reg == ST_IRQ && !vsel_taken_reg && vector_src_reg == SRC_WDOG |-> vector_addr_reg == OFF_WDOG)
    else $error("watchdog offset wrong");
  a_t2_offsets: assert property (@(posedge clk) disable iff (!rst_sync_n)
    state_reg == ST_IRQ && !vsel_taken_reg && vector_src_reg == SRC_T2_WRAP |-> vector_addr_reg == OFF_T2_WRAP)
    else $error("timer 2 overflow offset wrong");
  a_t1_offsets: assert property (@(posedge clk) disable iff (!rst_sync_n)
    state_reg == ST_IRQ && !vsel_taken_reg && vector_src_reg == SRC_T1_CAP |-> vector_addr_reg == OFF_T1_CAP)
    else $error("timer 1 capture offset wrong");
  a_t0_offsets: assert property (@(posedge clk) disable iff (!rst_sync_n)
    state_reg == ST_IRQ && !vsel_taken_reg && vector_src_reg == SRC_T0_WRAP |-> vector_addr_reg == OFF_T0_WRAP)
    else $error("timer 0 overflow offset wrong");
  a_spi_offset: assert property (@(posedge clk) disable iff (!rst_sync_n)
    state_reg == ST_IRQ && !vsel_taken_reg && vector_src_reg == SRC_SPI_DONE |-> vector_addr_reg == OFF_SPI_DONE)
    else $error("transfer complete offset wrong");
  a_serial_offsets: assert property (@(posedge clk) disable iff (!rst_sync_n)
    state_reg == ST_IRQ && !vsel_taken_reg && vector_src_reg == SRC_SER_TX |-> vector_addr_reg == OFF_SER_TX)
    else $error("serial transmit done offset wrong");
  a_adc_ee_offsets: assert property (@(posedge clk) disable iff (!rst_sync_n)
    state_reg == ST_IRQ && !vsel_taken_reg && vector_src_reg == SRC_EE_RDY |-> vector_addr_reg == OFF_EE_RDY)
    else $error("eeprom ready offset wrong");
  a_last_offsets: assert property (@(posedge clk) disable iff (!rst_sync_n)
    state_reg == ST_IRQ && !vsel_taken_reg && vector_src_reg == SRC_PROG_RDY |-> vector_addr_reg == OFF_PROG_RDY)
    else $error("program store ready offset wrong");
  a_boot_table: assert property (@(posedge clk) disable iff (!rst_sync_n)
    state_reg == ST_IRQ && vsel_taken_reg |-> vector_addr_reg == base_taken_reg + VEC_OFFSET[vector_src_reg])
    else $error("boot table address wrong");
  a_base_select: assert property (@(posedge clk) disable iff (!rst_sync_n)
    $rose(state_reg == ST_IRQ) && !$past(vector_table_select_bit) |-> vector_addr_reg < OFF_PROG_RDY + OFF_EXT0)
    else $error("table base moved without select bit");
  a_fetch_taken: assert property (@(posedge clk) disable iff (!rst_sync_n)
    $rose(state_reg == ST_IRQ) |-> $past(global_int_enable) && $past(irq_pending) != NO_PENDING)
    else $error("vector presented without taken interrupt");
  a_lowest_first: assert property (@(posedge clk) disable iff (!rst_sync_n)
    state_reg == ST_IRQ |-> (pend_snap_reg & ((ONE_SRC << vector_src_reg) - ONE_SRC)) == NO_PENDING)
    else $error("lower numbered request skipped");
  a_ext0_offset: assert property (@(posedge clk) disable iff (!rst_sync_n)
    state_reg == ST_IRQ && !vsel_taken_reg && vector_src_reg == SRC_EXT0 |-> vector_addr_reg == OFF_EXT0)
    else $error("external request 0 offset wrong");
  a_pin0_offset: assert property (@(posedge clk) disable iff (!rst_sync_n)
    state_reg == ST_IRQ && !vsel_taken_reg && vector_src_reg == SRC_PIN0 |-> vector_addr_reg == OFF_PIN0)
    else $error("pin change 0 offset wrong");
  a_pin1_offset: assert property (@(posedge clk) disable iff (!rst_sync_n)
    state_reg == ST_IRQ && !vsel_taken_reg && vector_src_reg == SRC_PIN1 |-> vector_addr_reg == OFF_PIN1)
    else $error("pin change 1 offset wrong");
  a_t2_cmpa_offset: assert property (@(posedge clk) disable iff (!rst_sync_n)
    state_reg == ST_IRQ && !vsel_taken_reg && vector_src_reg == SRC_T2_CMPA |-> vector_addr_reg == OFF_T2_CMPA)
    else $error("timer 2 compare a offset wrong");
  a_t2_cmpb_offset: assert property (@(posedge clk) disable iff (!rst_sync_n)
    state_reg == ST_IRQ && !vsel_taken_reg && vector_src_reg == SRC_T2_CMPB |-> vector_addr_reg == OFF_T2_CMPB)
    else $error("timer 2 compare b offset wrong");
  a_t1_cmpa_offset: assert property (@(posedge clk) disable iff (!rst_sync_n)
    state_reg == ST_IRQ && !vsel_taken_reg && vector_src_reg == SRC_T1_CMPA |-> vector_addr_reg == OFF_T1_CMPA)
    else $error("timer 1 compare a offset wrong");
  a_t1_cmpb_offset: assert property (@(posedge clk) disable iff (!rst_sync_n)
    state_reg == ST_IRQ && !vsel_taken_reg && vector_src_reg == SRC_T1_CMPB |-> vector_addr_reg == OFF_T1_CMPB)
    else $error("timer 1 compare b offset wrong");
  a_t1_wrap_offset: assert property (@(posedge clk) disable iff (!rst_sync_n)
    state_reg == ST_IRQ && !vsel_taken_reg && vector_src_reg == SRC_T1_WRAP |-> vector_addr_reg == OFF_T1_WRAP)
    else $error("timer 1 overflow offset wrong");
  a_t0_cmpa_offset: assert property (@(posedge clk) disable iff (!rst_sync_n)
    state_reg == ST_IRQ && !vsel_taken_reg && vector_src_reg == SRC_T0_CMPA |-> vector_addr_reg == OFF_T0_CMPA)
    else $error("timer 0 compare a offset wrong");
  a_t0_cmpb_offset: assert property (@(posedge clk) disable iff (!rst_sync_n)
    state_reg == ST_IRQ && !vsel_taken_reg && vector_src_reg == SRC_T0_CMPB |-> vector_addr_reg == OFF_T0_CMPB)
    else $error("timer 0 compare b offset wrong");
  a_ser_rx_offset: assert property (@(posedge clk) disable iff (!rst_sync_n)
    state_reg == ST_IRQ && !vsel_taken_reg && vector_src_reg == SRC_SER_RX |-> vector_addr_reg == OFF_SER_RX)
    else $error("serial receive offset wrong");
  a_ser_empty_offset: assert property (@(posedge clk) disable iff (!rst_sync_n)
    state_reg == ST_IRQ && !vsel_taken_reg && vector_src_reg == SRC_SER_EMPTY |-> vector_addr_reg == OFF_SER_EMPTY)
    else $error("serial buffer empty offset wrong");
  a_adc_offset: assert property (@(posedge clk) disable iff (!rst_sync_n)
    state_reg == ST_IRQ && !vsel_taken_reg && vector_src_reg == SRC_ADC_DONE |-> vector_addr_reg == OFF_ADC_DONE)
    else $error("converter done offset wrong");
  a_acomp_offset: assert property (@(posedge clk) disable iff (!rst_sync_n)
    state_reg == ST_IRQ && !vsel_taken_reg && vector_src_reg == SRC_ACOMP |-> vector_addr_reg == OFF_ACOMP)
    else $error("comparator offset wrong");
  a_two_wire_offset: assert property (@(posedge clk) disable iff (!rst_sync_n)
    state_reg == ST_IRQ && !vsel_taken_reg && vector_src_reg == SRC_TWO_WIRE |-> vector_addr_reg == OFF_TWO_WIRE)
    else $error("two-wire offset wrong");
  a_gap_after_ack: assert property (@(posedge clk) disable iff (!rst_sync_n)
    state_reg == ST_IRQ && vector_ack |=> !vector_valid)
    else $error("vector still presented after ack");

endmodule : ivm_vector_map

`default_nettype wire

// [verif/ivm_cpu_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// Fetch side model: acks each vector after a set wait
// ************************************************************
module ivm_cpu_model
  import ivm_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic [3:0]         ack_wait,
  input  wire logic               vector_valid,
  input  wire logic [ADDR_W-1:0]  vector_addr_reg,
  input  wire logic [SRC_W-1:0]   vector_src_reg,
  input  wire logic               vector_is_reset_reg,
  input  wire logic [NUM_SRC-1:0] irq_taken,
  output var  logic               vector_ack,
  output var  logic [ADDR_W-1:0]  got_addr,
  output var  logic [SRC_W-1:0]   got_src,
  output var  logic               got_reset,
  output var  logic [NUM_SRC-1:0] got_taken,
  output var  logic [7:0]         got_cnt
);
  logic [3:0] wait_cnt;

  // Ack changes off the falling edge so it stands across one rising edge
  always @(negedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      vector_ack <= 1'b0;
      wait_cnt   <= 4'h0;
    end
    else if (vector_ack)
    begin
      vector_ack <= 1'b0;
      wait_cnt   <= 4'h0;
    end
    else if (vector_valid)
    begin
      if (wait_cnt >= ack_wait)
        vector_ack <= 1'b1;
      else
        wait_cnt <= wait_cnt + 4'h1;
    end
  end

  // Capture at the edge where the ack is seen; taken is read pre-edge
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      got_cnt <= 8'h00;
    else if (vector_ack && vector_valid)
    begin
      got_addr  <= vector_addr_reg;
      got_src   <= vector_src_reg;
      got_reset <= vector_is_reset_reg;
      got_taken <= irq_taken;
      got_cnt   <= got_cnt + 8'h01;
    end
  end
endmodule : ivm_cpu_model
`default_nettype wire

// [verif/test_interrupt_vector_map.sv]
`timescale 1ns/100ps
`default_nettype none
module test_interrupt_vector_map;
  import ivm_pkg::*;
  logic               clk = 1'b0;
  logic               rstn, fuse, sel, gie, ack;
  logic [ADDR_W-1:0]  base, vaddr, g_addr;
  logic [SRC_W-1:0]   vsrc, g_src;
  logic               vrst, vvalid, g_rst;
  logic [NUM_SRC-1:0] pend, taken, g_taken;
  logic [7:0]         g_cnt;
  logic [3:0]         ack_wait;
  int                 n_fail = 0, n_checks = 0, cycles = 0;

  always #20 clk = ~clk;

  ivm_vector_map dut (.clk(clk), .rstn(rstn), .boot_reset_select_fuse(fuse), .vector_table_select_bit(sel),
    .boot_reset_addr(base), .global_int_enable(gie), .irq_pending(pend), .vector_ack(ack),
    .vector_addr_reg(vaddr), .vector_src_reg(vsrc), .vector_is_reset_reg(vrst), .vector_valid(vvalid),
    .irq_taken(taken));
  ivm_cpu_model cpu (.clk(clk), .rstn(rstn), .ack_wait(ack_wait), .vector_valid(vvalid),
    .vector_addr_reg(vaddr), .vector_src_reg(vsrc), .vector_is_reset_reg(vrst), .irq_taken(taken),
    .vector_ack(ack), .got_addr(g_addr), .got_src(g_src), .got_reset(g_rst), .got_taken(g_taken),
    .got_cnt(g_cnt));

  // ************************************************************
  // Checking helpers
  // ************************************************************
  task summarize;
    if (n_fail == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // Hang guard: whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      summarize();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // Returns on the falling edge after the fetch edge
  task wait_vec;
    logic [7:0] c0;
    logic       ok;
    int         k;
    c0 = g_cnt;
    ok = 1'b0;
    for (k = 0; k < 60 && !ok; k++)
    begin
      @(negedge clk);
      ok = (g_cnt !== c0);
    end
    check(32'(ok), 32'h1, "no vector fetched");
  endtask : wait_vec

  task do_reset(input logic f, input logic [ADDR_W-1:0] b, input logic [ADDR_W-1:0] exp);
    @(negedge clk);
    rstn = 1'b0;
    fuse = f;
    base = b;
    pend = '0;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    wait_vec();
    check(32'(g_addr), 32'(exp), "reset address");
    check(32'(g_rst), 32'h1, "reset flag");
  endtask : do_reset

  // Source drops its request as soon as the fetch is seen
  task expect_vec(input int s, input logic [ADDR_W-1:0] a);
    wait_vec();
    pend[s] = 1'b0;
    check(32'(g_src), 32'(s), "source");
    check(32'(g_addr), 32'(a), "vector address");
    check(32'(g_rst), 32'h0, "reset flag on irq");
    check(32'(g_taken), 32'(ONE_SRC << s), "taken pulse");
  endtask : expect_vec

  // ************************************************************
  // Scenarios
  // ************************************************************
  task t_reset;
    do_reset(1'b1, 12'hC00, 12'h000);
    do_reset(1'b0, 12'hC00, 12'hC00);
  endtask : t_reset

  // Fuse still programmed here: table must stay at base zero
  task t_table;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      pend[i] = 1'b1;
      expect_vec(i, 12'(i + 1));
    end
  endtask : t_table

  // Fuse programmed and select set; reset below must then ignore select
  task t_boot_table;
    sel = 1'b1;
    pend[1] = 1'b1;
    expect_vec(1, 12'hC02);
    do_reset(1'b1, 12'hC00, 12'h000);
    sel = 1'b1;
    pend[0] = 1'b1;
    expect_vec(0, 12'hC01);
    pend[24] = 1'b1;
    expect_vec(24, 12'hC19);
    sel = 1'b0;
    pend[5] = 1'b1;
    expect_vec(5, 12'h006);
  endtask : t_boot_table

  // Late lower request overtakes a pending higher one
  task t_priority;
    ack_wait = 4'h5;
    pend[7] = 1'b1;
    pend[3] = 1'b1;
    repeat (2) @(negedge clk);
    pend[0] = 1'b1;
    expect_vec(3, 12'h004);
    expect_vec(0, 12'h001);
    expect_vec(7, 12'h008);
    ack_wait = 4'h0;
  endtask : t_priority

  task t_refused;
    logic [7:0] c0;
    gie = 1'b0;
    pend[9] = 1'b1;
    c0 = g_cnt;
    repeat (20) @(negedge clk);
    check(32'(vvalid), 32'h0, "vector while disabled");
    check(32'(g_cnt), 32'(c0), "fetch while disabled");
    gie = 1'b1;
    expect_vec(9, 12'h00A);
  endtask : t_refused

  initial
  begin
    rstn = 1'b0;
    fuse = 1'b1;
    sel = 1'b0;
    base = 12'h000;
    gie = 1'b1;
    pend = '0;
    ack_wait = 4'h0;
    t_reset();
    t_table();
    t_boot_table();
    t_priority();
    t_refused();
    summarize();
  end
endmodule : test_interrupt_vector_map
`default_nettype wire
